// ### logic/ebs_defines.svh
// constants for the external brake sequencer
// assumes a 50 MHz drive clock and AXI4-Lite register access
`ifndef EBS_DEFINES_SVH
`define EBS_DEFINES_SVH

// ==================================================
// register byte offsets
`define EBS_OFF_CTRL     8'h00
`define EBS_OFF_RELWAIT  8'h04
`define EBS_OFF_ACCWAIT  8'h08
`define EBS_OFF_STOPWAIT 8'h0C
`define EBS_OFF_CONFWAIT 8'h10
`define EBS_OFF_RELFREQ  8'h14
`define EBS_OFF_RELCUR   8'h18
`define EBS_OFF_STATUS   8'h1C
`define EBS_OFF_IRQSTAT  8'h20
`define EBS_OFF_IRQMASK  8'h24
`define EBS_OFF_TARGET   8'h28

// ==================================================
// fields and codes
`define EBS_ENABLE_OFF   2'h0
`define EBS_ENABLE_ON    2'h1
`define EBS_CTRL_RUN_BIT 2
`define EBS_WAIT_MAX     16'h01F4
`define EBS_CUR_MAX      8'hC8
`define EBS_IRQ_RELEASE  0
`define EBS_IRQ_ENGAGE   1
`define EBS_IRQ_ERROR    2
`define EBS_IRQ_STOPPED  3

// ==================================================
// timing: one wait tick is 10 ms
`define EBS_TICK_NS      10000000
`define EBS_CLK_NS       20
`define EBS_TICK_CYCLES  (`EBS_TICK_NS / `EBS_CLK_NS)
`endif

// ### logic/ebs_pkg.sv
// types for the external brake sequencer
// assumes ebs_defines.svh is compiled alongside
package ebs_pkg;
  // ==================================================
  // sequencer states
  typedef enum logic [3:0] {
    IDLE, RAMP_UP, REL_WAIT, CONF_ON, ACC_WAIT, RUNNING,
    RAMP_DOWN, CONF_OFF, STOP_WAIT, STOPPING, TRIPPED
  } ebs_state_t;
endpackage

// ### logic/ebs_tick.sv
// ten millisecond tick generator
// assumes the drive clock and asynchronous active-low reset
`timescale 1ns/1ps
`include "ebs_defines.svh"
module ebs_tick #(
  parameter int TICK_CYCLES = `EBS_TICK_CYCLES
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // tick out
  output logic      tick
);
  logic [31:0] countReg;

  // ==================================================
  // free-running divider
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      countReg <= 32'h0;
      tick     <= 1'b0;
    end else if (countReg == 32'(TICK_CYCLES - 1)) begin
      countReg <= 32'h0;
      tick     <= 1'b1;
    end else begin
      countReg <= countReg + 32'h1;
      tick     <= 1'b0;
    end
  end
endmodule

// ### logic/ebs_axil.sv
// AXI4-Lite slave front end: one write and one read in flight
// assumes a master that holds valid and payload until ready
`timescale 1ns/1ps
module ebs_axil (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // write channels
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // read channels
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // register side
  output logic             wrStb,
  output logic [7:0]       wrAddr,
  output logic [31:0]      wrData,
  output logic [3:0]       wrStrb,
  input  wire logic        wrOk,
  output logic [7:0]       rdAddr,
  input  wire logic [31:0] rdValue,
  input  wire logic        rdOk
);
  logic awHave_reg;
  logic wHave_reg;

  assign awready = !awHave_reg && !bvalid;
  assign wready  = !wHave_reg && !bvalid;
  assign arready = !rvalid;
  assign wrStb   = awHave_reg && wHave_reg && !bvalid;
  assign rdAddr  = araddr;

  // ==================================================
  // capture address and data in either order
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      awHave_reg <= 1'b0;
      wHave_reg  <= 1'b0;
      wrAddr     <= 8'h00;
      wrData     <= 32'h0;
      wrStrb     <= 4'h0;
    end else if (wrStb) begin
      awHave_reg <= 1'b0;
      wHave_reg  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awHave_reg <= 1'b1;
        wrAddr     <= awaddr;
      end
      if (wvalid && wready) begin
        wHave_reg <= 1'b1;
        wrData    <= wdata;
        wrStrb    <= wstrb;
      end
    end
  end

  // ==================================================
  // write response, decerr on unmapped
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bvalid <= 1'b0;
      bresp  <= 2'h0;
    end else if (wrStb) begin
      bvalid <= 1'b1;
      bresp  <= wrOk ? 2'h0 : 2'h3;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ==================================================
  // read answer one cycle after address
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= 2'h0;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rdOk ? rdValue : 32'h0;
      rresp  <= rdOk ? 2'h0 : 2'h3;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

// ### logic/ebs_sequencer.sv
// external brake sequencer: top with registers and state machine
// assumes the current input synchronous to the 50 MHz clock
//
// Summary of operation
// - sequence runs only with enable code 01; any other code returns it to IDLE, except from TRIPPED.
// - run with enable ramps the frequency command to release frequency and holds.
// - at release frequency wait release delay before raising brake release.
// - current at or below release current when release due: no release, trip, error.
// - while release is on, hold release frequency until confirmation goes active.
// - after confirmation, wait accel delay then ramp to target frequency.
// - run off: decelerate to release frequency, then drop brake release.
// - hold release frequency while awaiting confirmation off; timeout trips with error.
// - after confirmation off, wait stop delay then decelerate to full stop.
// - entering CONF_ON or CONF_OFF starts a timed confirmation wait; expiry trips with error.
// - stop delay is programmable 0.00 to 5.00 s before decelerating to zero.
// - release current limit programmable 0 to 200 percent; current must exceed it.
// - confirmation active means brake open, inactive means brake engaged.
`timescale 1ns/1ps
`include "ebs_defines.svh"
module ebs_sequencer #(
  parameter int TICK_CYCLES = `EBS_TICK_CYCLES,
  parameter int FREQ_W      = 16
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rstn,
  // AXI4-Lite slave
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // drive measurements
  input  wire logic [7:0]        outputCurrent,
  // brake pins
  input  wire logic              brakeConfirmIn,
  output logic                   brakeReleaseOut,
  output logic                   brakeErrorOut,
  // frequency command to the drive ramp
  output logic [FREQ_W-1:0]      freqCommand,
  // interrupt
  output logic                   irq
);
  // ==================================================
  // declarations
  logic              tick;
  logic              wrStb;
  logic [7:0]        wrAddr;
  logic [31:0]       wrData;
  logic [3:0]        wrStrb;
  logic              wrOk;
  logic [7:0]        rdAddr;
  logic [31:0]       rdValue;
  logic              rdOk;
  logic [1:0]        enable_reg;
  logic              run_reg;
  logic              errClr;
  logic [15:0]       relWait_reg;
  logic [15:0]       accWait_reg;
  logic [15:0]       stopWait_reg;
  logic [15:0]       confWait_reg;
  logic [FREQ_W-1:0] relFreq_reg;
  logic [FREQ_W-1:0] target_reg;
  logic [7:0]        relCur_reg;
  logic [3:0]        irqStat_reg;
  logic [3:0]        irqMask_reg;
  logic [3:0]        events;
  logic [15:0]       timer_reg;
  logic              timerLoad;
  logic [15:0]       timerLoadVal;
  logic              timerDone;
  ebs_pkg::ebs_state_t state_reg;
  ebs_pkg::ebs_state_t state_next;

  // clamp a programmed delay to its 5.00 s ceiling
  function automatic logic [15:0] clampWait(input logic [31:0] v);
    clampWait = (v[15:0] > `EBS_WAIT_MAX) ? `EBS_WAIT_MAX : v[15:0];
  endfunction

  // one step of the frequency ramp toward a goal
  function automatic logic [FREQ_W-1:0] stepToward(input logic [FREQ_W-1:0] cur,
                                                   input logic [FREQ_W-1:0] goal);
    if (cur < goal) stepToward = cur + FREQ_W'(1);
    else if (cur > goal) stepToward = cur - FREQ_W'(1);
    else stepToward = cur;
  endfunction

  // ==================================================
  // submodules
  ebs_tick #(.TICK_CYCLES(TICK_CYCLES)) uTick (
    .clock (clock),
    .rstn  (rstn),
    .tick  (tick)
  );

  ebs_axil uBus (
    .clock   (clock),   .rstn    (rstn),
    .awaddr  (awaddr),  .awvalid (awvalid), .awready (awready),
    .wdata   (wdata),   .wstrb   (wstrb),   .wvalid  (wvalid),  .wready (wready),
    .bresp   (bresp),   .bvalid  (bvalid),  .bready  (bready),
    .araddr  (araddr),  .arvalid (arvalid), .arready (arready),
    .rdata   (rdata),   .rresp   (rresp),   .rvalid  (rvalid),  .rready (rready),
    .wrStb   (wrStb),   .wrAddr  (wrAddr),  .wrData  (wrData),  .wrStrb (wrStrb),
    .wrOk    (wrOk),    .rdAddr  (rdAddr),  .rdValue (rdValue), .rdOk   (rdOk)
  );

  // ==================================================
  // register writes (whole-word, committed only when strobe bit 0 is set)
  assign wrOk   = (wrAddr <= `EBS_OFF_TARGET) && (wrAddr[1:0] == 2'h0);
  assign errClr = wrStb && wrAddr == `EBS_OFF_CTRL && wrStrb[0] && wrData[3];

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      enable_reg   <= `EBS_ENABLE_OFF;
      run_reg      <= 1'b0;
      relWait_reg  <= 16'h0;
      accWait_reg  <= 16'h0;
      stopWait_reg <= 16'h0;
      confWait_reg <= 16'h0;
      relFreq_reg  <= '0;
      target_reg   <= '0;
      relCur_reg   <= 8'h00;
      irqMask_reg  <= 4'h0;
    end else if (wrStb && wrStrb[0]) begin
      unique case (wrAddr)
        `EBS_OFF_CTRL: begin
          enable_reg <= wrData[1:0];
          run_reg    <= wrData[`EBS_CTRL_RUN_BIT];
        end
        `EBS_OFF_RELWAIT:  relWait_reg  <= clampWait(wrData);
        `EBS_OFF_ACCWAIT:  accWait_reg  <= clampWait(wrData);
        `EBS_OFF_STOPWAIT: stopWait_reg <= clampWait(wrData);
        `EBS_OFF_CONFWAIT: confWait_reg <= clampWait(wrData);
        `EBS_OFF_RELFREQ:  relFreq_reg  <= wrData[FREQ_W-1:0];
        `EBS_OFF_RELCUR:   relCur_reg   <= (wrData[7:0] > `EBS_CUR_MAX) ? `EBS_CUR_MAX : wrData[7:0];
        `EBS_OFF_IRQMASK:  irqMask_reg  <= wrData[3:0];
        `EBS_OFF_TARGET:   target_reg   <= wrData[FREQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ==================================================
  // register reads
  always_comb begin
    rdOk    = 1'b1;
    rdValue = 32'h0;
    unique case (rdAddr)
      `EBS_OFF_CTRL:     rdValue = {29'h0, run_reg, enable_reg};
      `EBS_OFF_RELWAIT:  rdValue = {16'h0, relWait_reg};
      `EBS_OFF_ACCWAIT:  rdValue = {16'h0, accWait_reg};
      `EBS_OFF_STOPWAIT: rdValue = {16'h0, stopWait_reg};
      `EBS_OFF_CONFWAIT: rdValue = {16'h0, confWait_reg};
      `EBS_OFF_RELFREQ:  rdValue = 32'(relFreq_reg);
      `EBS_OFF_RELCUR:   rdValue = {24'h0, relCur_reg};
      `EBS_OFF_STATUS:   rdValue = {25'h0, brakeConfirmIn, brakeErrorOut, brakeReleaseOut, state_reg};
      `EBS_OFF_IRQSTAT:  rdValue = {28'h0, irqStat_reg};
      `EBS_OFF_IRQMASK:  rdValue = {28'h0, irqMask_reg};
      `EBS_OFF_TARGET:   rdValue = 32'(target_reg);
      default:           rdOk    = 1'b0;
    endcase
  end

  // ==================================================
  // delay timer in 10 ms ticks, zero means expired
  assign timerDone = (timer_reg == 16'h0);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timer_reg <= 16'h0;
    end else if (timerLoad) begin
      timer_reg <= timerLoadVal;
    end else if (tick && !timerDone) begin
      timer_reg <= timer_reg - 16'h1;
    end
  end

  // ==================================================
  // next state and timer loads
  always_comb begin
    state_next   = state_reg;
    timerLoad    = 1'b0;
    timerLoadVal = 16'h0;
    unique case (state_reg)
      ebs_pkg::IDLE:
        if (enable_reg == `EBS_ENABLE_ON && run_reg) state_next = ebs_pkg::RAMP_UP;
      ebs_pkg::RAMP_UP:
        if (freqCommand == relFreq_reg) begin
          state_next   = ebs_pkg::REL_WAIT;
          timerLoad    = 1'b1;
          timerLoadVal = relWait_reg;
        end
      ebs_pkg::REL_WAIT:
        if (timerDone) begin
          if (outputCurrent <= relCur_reg) state_next = ebs_pkg::TRIPPED;
          else begin
            state_next   = ebs_pkg::CONF_ON;
            timerLoad    = 1'b1;
            timerLoadVal = confWait_reg;
          end
        end
      ebs_pkg::CONF_ON:
        if (brakeConfirmIn) begin
          state_next   = ebs_pkg::ACC_WAIT;
          timerLoad    = 1'b1;
          timerLoadVal = accWait_reg;
        end else if (timerDone) state_next = ebs_pkg::TRIPPED;
      ebs_pkg::ACC_WAIT:
        if (timerDone) state_next = ebs_pkg::RUNNING;
      ebs_pkg::RUNNING:
        if (!run_reg) state_next = ebs_pkg::RAMP_DOWN;
      ebs_pkg::RAMP_DOWN:
        if (freqCommand == relFreq_reg) begin
          state_next   = ebs_pkg::CONF_OFF;
          timerLoad    = 1'b1;
          timerLoadVal = confWait_reg;
        end
      ebs_pkg::CONF_OFF:
        if (!brakeConfirmIn) begin
          state_next   = ebs_pkg::STOP_WAIT;
          timerLoad    = 1'b1;
          timerLoadVal = stopWait_reg;
        end else if (timerDone) state_next = ebs_pkg::TRIPPED;
      ebs_pkg::STOP_WAIT:
        if (timerDone) state_next = ebs_pkg::STOPPING;
      ebs_pkg::STOPPING:
        if (freqCommand == '0) state_next = ebs_pkg::IDLE;
      ebs_pkg::TRIPPED:
        if (errClr) state_next = ebs_pkg::IDLE;
      default: state_next = ebs_pkg::IDLE;
    endcase
    // disabling mid-sequence abandons it (any code but 01), except in TRIPPED
    if (enable_reg != `EBS_ENABLE_ON && state_reg != ebs_pkg::TRIPPED) state_next = ebs_pkg::IDLE;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) state_reg <= ebs_pkg::IDLE;
    else state_reg <= state_next;
  end

  // ==================================================
  // frequency command ramp, one step per tick; IDLE and TRIPPED force zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      freqCommand <= '0;
    end else if (tick) begin
      unique case (state_reg)
        ebs_pkg::RAMP_UP, ebs_pkg::RAMP_DOWN: freqCommand <= stepToward(freqCommand, relFreq_reg);
        ebs_pkg::RUNNING:  freqCommand <= stepToward(freqCommand, target_reg);
        ebs_pkg::STOPPING: freqCommand <= stepToward(freqCommand, '0);
        ebs_pkg::IDLE, ebs_pkg::TRIPPED: freqCommand <= '0;
        default: ;                                        // hold at release freq
      endcase
    end
  end

  // ==================================================
  // brake pins
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      brakeReleaseOut <= 1'b0;
      brakeErrorOut   <= 1'b0;
    end else begin
      brakeReleaseOut <= (state_next == ebs_pkg::CONF_ON) || (state_next == ebs_pkg::ACC_WAIT) ||
                         (state_next == ebs_pkg::RUNNING) || (state_next == ebs_pkg::RAMP_DOWN);
      brakeErrorOut   <= (state_next == ebs_pkg::TRIPPED);
    end
  end

  // ==================================================
  // sticky interrupts: set wins over write-one clear
  assign events[`EBS_IRQ_RELEASE] = state_reg == ebs_pkg::REL_WAIT && state_next == ebs_pkg::CONF_ON;
  assign events[`EBS_IRQ_ENGAGE]  = state_reg == ebs_pkg::RAMP_DOWN && state_next == ebs_pkg::CONF_OFF;
  assign events[`EBS_IRQ_ERROR]   = state_reg != ebs_pkg::TRIPPED && state_next == ebs_pkg::TRIPPED;
  assign events[`EBS_IRQ_STOPPED] = state_reg == ebs_pkg::STOPPING && state_next == ebs_pkg::IDLE;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) irqStat_reg <= 4'h0;
    else if (wrStb && wrStrb[0] && wrAddr == `EBS_OFF_IRQSTAT) irqStat_reg <= (irqStat_reg & ~wrData[3:0]) | events;
    else irqStat_reg <= irqStat_reg | events;
  end

  assign irq = |(irqStat_reg & irqMask_reg);
endmodule

// ### bench/ebs_sequencer_asserts.sv
// concurrent checks on the brake sequencer top ports
// assumes a bind into ebs_sequencer; one clock domain
`timescale 1ns/1ps
module ebs_sequencer_asserts #(
  parameter int FREQ_W = 16
) (
  // clock and reset
  input wire logic              clock,
  input wire logic              rstn,
  // bus handshakes
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic [1:0]        bresp,
  input wire logic              bvalid,
  input wire logic              bready,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [31:0]       rdata,
  input wire logic              rvalid,
  input wire logic              rready,
  // brake pins and speed
  input wire logic              brakeConfirmIn,
  input wire logic              brakeReleaseOut,
  input wire logic              brakeErrorOut,
  input wire logic [FREQ_W-1:0] freqCommand
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // ==================================================
  // sequences
  // address and data taken together
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  // brake opening, contact not yet closed
  sequence s_rel_pending;
    (brakeReleaseOut && !brakeConfirmIn && !brakeErrorOut) [*2];
  endsequence
  // brake closing, contact not yet open
  sequence s_eng_pending;
    (!brakeReleaseOut && brakeConfirmIn && !brakeErrorOut) [*2];
  endsequence
  // ==================================================
  // properties
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] bvalid)
    else $error("write response late");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_freq_step: assert property (
    !brakeErrorOut |-> freqCommand == $past(freqCommand) || freqCommand == $past(freqCommand) + 1'b1
      || freqCommand + 1'b1 == $past(freqCommand))
    else $error("frequency jumped");
  a_release_hold: assert property (s_rel_pending |-> $stable(freqCommand))
    else $error("speed moved before contact closed");
  a_engage_hold: assert property (s_eng_pending |-> $stable(freqCommand))
    else $error("speed moved before brake engaged");
  a_error_sticky: assert property (
    brakeErrorOut && !(awvalid || $past(awvalid) || $past(awvalid, 2) || $past(awvalid, 3)) |=> brakeErrorOut)
    else $error("brake error cleared without a write");
endmodule

bind ebs_sequencer ebs_sequencer_asserts #(.FREQ_W(FREQ_W)) chk (
  .clock, .rstn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready,
  .rdata, .rvalid, .rready, .brakeConfirmIn, .brakeReleaseOut, .brakeErrorOut, .freqCommand
);

// ### bench/ebs_brake_model.sv
// brake mechanism with its confirmation contact
// assumes the drive clock; lag and stuck come from the bench
`timescale 1ns/1ps
module ebs_brake_model (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // behaviour controls
  input  wire logic [7:0] lagCycles,
  input  wire logic       stuck,
  // brake pins
  input  wire logic       brakeReleaseOut,
  output logic            brakeConfirmIn
);
  logic [7:0] lagCnt_reg;
  // contact follows the coil after a lag; stuck freezes it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lagCnt_reg     <= 8'h00;
      brakeConfirmIn <= 1'b0;
    end else if (stuck || brakeConfirmIn == brakeReleaseOut) begin
      lagCnt_reg <= 8'h00;
    end else if (lagCnt_reg >= lagCycles) begin
      brakeConfirmIn <= brakeReleaseOut;
      lagCnt_reg     <= 8'h00;
    end else begin
      lagCnt_reg <= lagCnt_reg + 8'h01;
    end
  end
endmodule

// ### bench/external_brake_sequencer_test.sv
// self-checking bench for the brake sequencer
// assumes the brake model and the bound checker are compiled
`timescale 1ns/1ps
`include "ebs_defines.svh"
module external_brake_sequencer_test;
  // ==================================================
  // signals
  logic        clock = 1'b0, rstn = 1'b0, stuck = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, outputCurrent = 8'h00, lagCycles = 8'h14;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic        brakeConfirmIn, brakeReleaseOut, brakeErrorOut;
  logic [15:0] freqCommand;
  int          err_count = 0, n_compared = 0, n;
  // 50 MHz clock
  always #10 clock = ~clock;
  // design and brake
  ebs_sequencer #(.TICK_CYCLES(4), .FREQ_W(16)) uut (
    .clock(clock), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .outputCurrent(outputCurrent), .brakeConfirmIn(brakeConfirmIn),
    .brakeReleaseOut(brakeReleaseOut), .brakeErrorOut(brakeErrorOut), .freqCommand(freqCommand), .irq(irq)
  );
  ebs_brake_model brake (
    .clock(clock), .rstn(rstn), .lagCycles(lagCycles), .stuck(stuck),
    .brakeReleaseOut(brakeReleaseOut), .brakeConfirmIn(brakeConfirmIn)
  );
  // ==================================================
  // helpers
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // handshakes are judged on values settled before the rising edge
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    @(posedge clock);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge clock);
      aw = awvalid & awready;
      w  = wvalid & wready;
      b  = bvalid;
      r  = bresp;
      @(posedge clock);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(negedge clock);
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, rv;
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    rv = 1'b0;
    while (!rv) begin
      @(negedge clock);
      ar = arvalid & arready;
      rv = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge clock);
      if (ar) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(negedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check("write resp", 32'(r), 32'h0);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check({nm, " resp"}, 32'(r), 32'(er));
    if (er == 2'h0) check(nm, d, e);
  endtask
  // ==================================================
  // scenarios
  task automatic t_regs();
    logic [1:0] r;
    rdchk("ctrl reset", `EBS_OFF_CTRL, 32'h0, 2'h0);
    wr(`EBS_OFF_CONFWAIT, 32'h0000FFFF);
    rdchk("wait clamp", `EBS_OFF_CONFWAIT, {16'h0, `EBS_WAIT_MAX}, 2'h0);
    wr(`EBS_OFF_RELCUR, 32'h000000FF);
    rdchk("current clamp", `EBS_OFF_RELCUR, {24'h0, `EBS_CUR_MAX}, 2'h0);
    axi_write(8'h30, 32'h1, r);
    check("unmapped write", 32'(r), 32'h3);
    rdchk("unmapped read", 8'h30, 32'h0, 2'h3);
  endtask
  task automatic t_cfg();
    logic [7:0]  a[8] = '{`EBS_OFF_RELFREQ, `EBS_OFF_TARGET, `EBS_OFF_RELWAIT, `EBS_OFF_ACCWAIT,
                          `EBS_OFF_STOPWAIT, `EBS_OFF_CONFWAIT, `EBS_OFF_RELCUR, `EBS_OFF_IRQMASK};
    logic [31:0] d[8] = '{32'h5, 32'hA, 32'h2, 32'h2, 32'h2, 32'h14, 32'h32, 32'hF};
    for (int i = 0; i < 8; i++) wr(a[i], d[i]);
  endtask
  task automatic t_disabled();
    outputCurrent <= 8'h64;
    wr(`EBS_OFF_CTRL, 32'h4);
    repeat (100) @(negedge clock);
    check("disabled freq", 32'(freqCommand), 32'h0);
    check("disabled release", 32'(brakeReleaseOut), 32'h0);
    wr(`EBS_OFF_CTRL, 32'h0);
  endtask
  task automatic t_run();
    wr(`EBS_OFF_CTRL, 32'h5);
    for (n = 0; n < 2000 && freqCommand !== 16'h0005; n++) @(negedge clock);
    for (n = 0; n < 2000 && brakeReleaseOut !== 1'b1; n++) @(negedge clock);
    check("release delay", 32'(n >= 8 && n <= 14), 32'h1);
    check("release freq", 32'(freqCommand), 32'h5);
    for (n = 0; n < 2000 && brakeConfirmIn !== 1'b1; n++) @(negedge clock);
    for (n = 0; n < 2000 && freqCommand !== 16'h0006; n++) @(negedge clock);
    check("accel delay", 32'(n >= 8 && n <= 14), 32'h1);
    for (n = 0; n < 2000 && freqCommand !== 16'h000A; n++) @(negedge clock);
    rdchk("status running", `EBS_OFF_STATUS, 32'h55, 2'h0);
    wr(`EBS_OFF_CTRL, 32'h1);
    for (n = 0; n < 2000 && brakeReleaseOut !== 1'b0; n++) @(negedge clock);
    check("engage freq", 32'(freqCommand), 32'h5);
    for (n = 0; n < 2000 && brakeConfirmIn !== 1'b0; n++) @(negedge clock);
    for (n = 0; n < 2000 && freqCommand !== 16'h0004; n++) @(negedge clock);
    check("stop delay", 32'(n >= 8 && n <= 14), 32'h1);
    for (n = 0; n < 2000 && freqCommand !== 16'h0000; n++) @(negedge clock);
    repeat (10) @(negedge clock);
    rdchk("status idle", `EBS_OFF_STATUS, 32'h0, 2'h0);
    rdchk("irq events", `EBS_OFF_IRQSTAT, 32'hB, 2'h0);
    check("irq raised", 32'(irq), 32'h1);
    wr(`EBS_OFF_IRQSTAT, 32'hF);
    check("irq cleared", 32'(irq), 32'h0);
  endtask
  task automatic t_low_current();
    wr(`EBS_OFF_IRQMASK, 32'h0);
    outputCurrent <= 8'h32;
    wr(`EBS_OFF_CTRL, 32'h5);
    for (n = 0; n < 2000 && brakeErrorOut !== 1'b1; n++) @(negedge clock);
    check("current trip", 32'(brakeErrorOut), 32'h1);
    check("no release", 32'(brakeReleaseOut), 32'h0);
    check("irq masked", 32'(irq), 32'h0);
    wr(`EBS_OFF_IRQMASK, 32'h4);
    check("irq unmasked", 32'(irq), 32'h1);
    wr(`EBS_OFF_CTRL, 32'h9);
    repeat (4) @(negedge clock);
    check("trip cleared", 32'(brakeErrorOut), 32'h0);
    wr(`EBS_OFF_IRQSTAT, 32'h4);
    check("irq off", 32'(irq), 32'h0);
  endtask
  task automatic t_conf_timeout();
    wr(`EBS_OFF_CONFWAIT, 32'h3);
    stuck <= 1'b1;
    outputCurrent <= 8'h64;
    wr(`EBS_OFF_CTRL, 32'h5);
    for (n = 0; n < 2000 && brakeReleaseOut !== 1'b1; n++) @(negedge clock);
    for (n = 0; n < 2000 && brakeErrorOut !== 1'b1; n++) @(negedge clock);
    check("confirm timeout", 32'(n >= 12 && n <= 18), 32'h1);
    rdchk("irq trip", `EBS_OFF_IRQSTAT, 32'h5, 2'h0);
  endtask
  // ==================================================
  // main sequence and watchdog
  initial begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    t_regs();
    t_cfg();
    t_disabled();
    t_run();
    t_low_current();
    t_conf_timeout();
    end_of_test();
  end
  initial begin
    #800000;
    err_count++;
    end_of_test();
  end
endmodule
